// ===== ddr2_burst_dev.sv
/*
  DDR2 memory side: command decode on rising memory clock, bank/row
  state, bursts of 4 or 8 with strobes, auto precharge, self refresh
  and power-down flags. Memory clock and write strobes are pins,
  sampled by clk and edge detected; memory clock runs far slower.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a four-beat access moves one 4n core word as four half-clock pin transfers; an eight-beat access moves two.
// - memory drives strobes on reads; controller drives them on writes.
// - read strobe edges align with data; write strobes centre in data eye.
// - sixteen-bit bus uses separate strobes for low and high byte.
// - commands sampled on each rising edge of the true memory clock.
// - write data captured on both strobe edges; reads on both clock edges.
// - bursts start at addressed column and follow programmed ordering.
// - activate picks bank and row from bank and address lines.
// - read or write picks bank and starting column.
// - burst length programmable as four or eight.
// - any running burst, four- or eight-long, is cut by a new read or write to an open bank.
// - auto precharge closes the row itself after the burst ends.
// - banks run independently during another bank's burst.
// - self refresh keeps contents; power-down saves power separately.
// - precharge address bit 10 low means one bank, high means all.
// - bank lines pick bank, and mode register for load mode.
module ddr2_burst_dev (
  input wire logic clk, // system clock, 25 MHz
  input wire logic reset_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic ck_pin, // memory clock, true phase
  input wire ddr2_burst_pkg::cmd_pins_t cmd_pin, // command/address pins
  input wire ddr2_burst_pkg::data_pins_t data_in, // dq and strobes, input
  output ddr2_burst_pkg::data_pins_t data_out, // dq and strobes, output
  output logic [ddr2_burst_pkg::LANES-1:0] dqs_oe, // strobe drive, per byte
  output logic [ddr2_burst_pkg::DQ_W-1:0] dq_oe, // data drive
  output logic self_refresh, // self refresh state
  output logic power_down // power-down state
);
  localparam int DQ_W = ddr2_burst_pkg::DQ_W;
  localparam int BANKS = ddr2_burst_pkg::BANKS;
  localparam int AW = ddr2_burst_pkg::ADDR_W;
  localparam int BW = ddr2_burst_pkg::BANK_W;

  typedef enum {ST_IDLE, ST_RD_WAIT, ST_RD, ST_WR} bst_t;

  // =====================================================
  // pin sampling (memory clock and write strobes are asynchronous)
  logic ck_s;
  logic ck_prev_q;
  logic [ddr2_burst_pkg::LANES-1:0] dqs_s;
  logic [ddr2_burst_pkg::LANES-1:0] dqs_prev_q;
  ddr2_burst_pkg::cmd_pins_t cmd_s;
  logic [DQ_W-1:0] dq_s;

  ddr2_pin_sync #(.W(1 + $bits(cmd_pin) + DQ_W + ddr2_burst_pkg::LANES))
    u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .d({ck_pin, cmd_pin, data_in.dq, data_in.dqs}),
    .q({ck_s, cmd_s, dq_s, dqs_s})
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ck_prev_q <= 1'b0;
      dqs_prev_q <= '0;
    end else if (ce) begin
      ck_prev_q <= ck_s;
      dqs_prev_q <= dqs_s;
    end
  end

  logic ck_rise;
  logic ck_edge;
  logic [ddr2_burst_pkg::LANES-1:0] dqs_edge;
  assign ck_rise = ck_s && !ck_prev_q;
  assign ck_edge = ck_s != ck_prev_q;
  assign dqs_edge = dqs_s ^ dqs_prev_q;

  // =====================================================
  // command decode
  function automatic logic is_cmd(input ddr2_burst_pkg::cmd_pins_t c,
                                  input logic [3:0] code);
    is_cmd = c.cke && (c.code == code);
  endfunction

  logic take; // one command per rising memory clock
  assign take = ce && ck_rise && !self_refresh;
  logic do_act, do_rd, do_wr, do_pre, do_lmr, do_ref;
  assign do_act = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_ACT);
  assign do_rd = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_RD);
  assign do_wr = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_WR);
  assign do_pre = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_PRE);
  assign do_lmr = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_LMR);
  assign do_ref = take && is_cmd(cmd_s, ddr2_burst_pkg::CMD_REF);

  // =====================================================
  // mode register
  logic [AW-1:0] mode_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_q <= ddr2_burst_pkg::MR_RESET;
    end else if (do_lmr && cmd_s.bank == ddr2_burst_pkg::MR_SEL_MODE) begin
      mode_q <= cmd_s.addr;
    end
  end
  logic bl8;
  logic interleave;
  assign bl8 = mode_q[ddr2_burst_pkg::MR_BL_LSB +: 3] ==
               ddr2_burst_pkg::MR_BL8;
  assign interleave = mode_q[ddr2_burst_pkg::MR_BT_BIT];

  // =====================================================
  // power states; cke low with refresh code enters self refresh
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      self_refresh <= 1'b0;
      power_down <= 1'b0;
    end else if (ce && ck_rise) begin
      self_refresh <= !cmd_s.cke && (self_refresh ||
                      cmd_s.code == ddr2_burst_pkg::CMD_REF);
      power_down <= !cmd_s.cke && !self_refresh &&
                    cmd_s.code != ddr2_burst_pkg::CMD_REF;
    end
  end

  // =====================================================
  // bank state, banks independent of each other
  logic [BANKS-1:0] open_q;
  logic [AW-1:0] row_q [BANKS];
  logic [BANKS-1:0] ap_pend_q;
  logic burst_end;
  logic [ddr2_burst_pkg::BANK_W-1:0] bank_q;
  logic ap_q;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      logic hit;
      assign hit = cmd_s.bank == BW'(b);
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          open_q[b] <= 1'b0;
          row_q[b] <= '0;
          ap_pend_q[b] <= 1'b0;
        end else begin
          if (do_act && hit) begin
            open_q[b] <= 1'b1;
            row_q[b] <= cmd_s.addr;
          end else if (do_pre && (hit || cmd_s.addr[ddr2_burst_pkg::AP_BIT])) begin
            open_q[b] <= 1'b0;
          end else if (burst_end && ap_pend_q[b]) begin
            open_q[b] <= 1'b0;
          end
          if ((do_rd || do_wr) && hit) begin
            ap_pend_q[b] <= cmd_s.addr[ddr2_burst_pkg::AP_BIT];
          end else if (burst_end) begin
            ap_pend_q[b] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // =====================================================
  // burst engine
  bst_t st_q;
  logic [2:0] beat_q;
  logic [2:0] col_q;
  logic [ddr2_burst_pkg::COL_W-1:0] base_q;
  logic [3:0] lat_q;
  logic is8_q;

  // accesses to a closed bank are ignored; controller tracks them
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = do_rd && open_q[cmd_s.bank];
  assign wr_ok = do_wr && open_q[cmd_s.bank];

  // a new read or write to an open bank cuts any running burst
  logic last_beat;
  assign last_beat = beat_q == (is8_q ? 3'h7 : 3'h3);
  // write beats follow the strobe, so a clock edge must not end them early
  assign burst_end = ce && last_beat &&
                     ((st_q == ST_RD && ck_edge) ||
                      (st_q == ST_WR && dqs_edge[0]));

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ST_IDLE;
      beat_q <= '0;
      base_q <= '0;
      bank_q <= '0;
      lat_q <= '0;
      is8_q <= 1'b0;
      ap_q <= 1'b0;
    end else if (ce) begin
      if (rd_ok || wr_ok) begin
        st_q <= rd_ok ? ST_RD_WAIT : ST_WR;
        beat_q <= '0;
        base_q <= cmd_s.addr[ddr2_burst_pkg::COL_W-1:0];
        bank_q <= cmd_s.bank;
        lat_q <= ddr2_burst_pkg::READ_LAT;
        is8_q <= bl8;
        ap_q <= cmd_s.addr[ddr2_burst_pkg::AP_BIT];
      end else begin
        unique case (st_q)
          ST_IDLE: begin
          end
          ST_RD_WAIT: begin
            if (ck_rise) begin
              lat_q <= lat_q - 4'h1;
              if (lat_q == 4'h1) begin
                st_q <= ST_RD;
              end
            end
          end
          ST_RD: begin
            if (ck_edge) begin // both clock edges
              beat_q <= beat_q + 3'h1;
              if (last_beat) begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_WR: begin
            if (dqs_edge[0]) begin // both strobe edges
              beat_q <= beat_q + 3'h1;
              if (last_beat) begin
                st_q <= ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // burst order within the 4- or 8-block holding the start column
  always_comb begin
    logic [2:0] s;
    s = base_q[2:0];
    if (interleave) begin
      col_q = s ^ beat_q;
    end else begin
      col_q = s + beat_q;
    end
    if (!is8_q) begin
      col_q[2] = s[2];
    end
  end

  // =====================================================
  // storage: 4n core word split into four beats
  logic [DQ_W-1:0] mem_q [ddr2_burst_pkg::MEM_DEPTH];
  logic [ddr2_burst_pkg::MEM_AW-1:0] mem_a;
  assign mem_a = {bank_q, row_q[bank_q][0], col_q};

  logic wr_beat;
  assign wr_beat = ce && st_q == ST_WR && dqs_edge[0] &&
                   !(rd_ok || wr_ok);
  // per-byte strobe times its own lane
  always_ff @(posedge clk) begin
    if (ce && st_q == ST_WR && dqs_edge[0] && !(rd_ok || wr_ok)) begin
      mem_q[mem_a][7:0] <= dq_s[7:0];
    end
    if (ce && st_q == ST_WR && dqs_edge[1] && !(rd_ok || wr_ok)) begin
      mem_q[mem_a][15:8] <= dq_s[15:8];
    end
  end

  // =====================================================
  // read drive: strobe toggles with each data change
  logic [ddr2_burst_pkg::LANES-1:0] dqs_q;
  logic [DQ_W-1:0] dq_q;
  logic rd_drive_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dqs_q <= '0;
      dq_q <= '0;
      rd_drive_q <= 1'b0;
    end else if (ce) begin
      rd_drive_q <= st_q == ST_RD;
      if (st_q == ST_RD && ck_edge) begin
        dq_q <= mem_q[mem_a];
        dqs_q <= ~dqs_q; // edge aligned, both lanes
      end else if (st_q != ST_RD) begin
        dqs_q <= '0;
      end
    end
  end

  assign data_out.dq = dq_q;
  assign data_out.dqs = dqs_q;
  assign dqs_oe = {ddr2_burst_pkg::LANES{rd_drive_q}};
  assign dq_oe = {DQ_W{rd_drive_q}};

  logic unused_ok;
  assign unused_ok = wr_beat | do_ref | ap_q | (^data_in.dqs);
endmodule
`default_nettype wire

// ===== ddr2_burst_dev_sva.sv
/* checker for the DDR2 burst device ports.
   assumes the bench moves pins only on the clk falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst_dev_sva (
  input wire logic clk, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic ck_pin, // memory clock pin
  input wire ddr2_burst_pkg::cmd_pins_t cmd_pin, // command pins
  input wire ddr2_burst_pkg::data_pins_t data_out, // device drive
  input wire logic [ddr2_burst_pkg::LANES-1:0] dqs_oe, // strobe enable
  input wire logic [ddr2_burst_pkg::DQ_W-1:0] dq_oe, // data enable
  input wire logic self_refresh, // self refresh flag
  input wire logic power_down // power-down flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==================================================
  // helper counters
  logic ck_q;
  logic [7:0] since_rd;
  logic [7:0] run;
  logic [7:0] cke_lo;
  always_ff @(posedge clk) ck_q <= ck_pin;
  always_ff @(posedge clk) begin
    if (!reset_n) since_rd <= 8'hff;
    else if (ck_pin && !ck_q && cmd_pin.cke &&
             cmd_pin.code == ddr2_burst_pkg::CMD_RD) since_rd <= 8'h00;
    else if (since_rd != 8'hff) since_rd <= since_rd + 8'h01;
  end
  always_ff @(posedge clk) run <= dqs_oe[0] ? run + 8'h01 : 8'h00;
  always_ff @(posedge clk) cke_lo <= cmd_pin.cke ? 8'h00 : cke_lo + 8'h01;
  // ==================================================
  // properties
  sequence s_beat;
    dqs_oe[0] && $changed(data_out.dqs[0]);
  endsequence
  a_reset_quiet: assert property ($rose(reset_n) |-> dqs_oe == 2'h0 &&
    dq_oe == 16'h0 && !self_refresh && !power_down) else $error("busy after reset");
  a_read_lat: assert property ($rose(dqs_oe[0]) |->
    since_rd >= 8'h0c && since_rd <= 8'h28) else $error("read drive late");
  a_half_beat: assert property (s_beat |=> $stable(data_out.dqs[0]) [*2])
    else $error("strobe beat too short");
  a_eye_hold: assert property (s_beat |=> $stable(data_out.dq) [*2])
    else $error("data moved off strobe edge");
  a_lane_pair: assert property (dqs_oe[0] |-> dqs_oe[1] &&
    data_out.dqs[1] == data_out.dqs[0]) else $error("byte strobes differ");
  a_burst_len: assert property ($fell(dqs_oe[0]) |->
    run >= 8'h0e && run <= 8'h3c) else $error("burst length off");
  a_sr_quiet: assert property (self_refresh |-> dqs_oe == 2'h0 &&
    !power_down) else $error("drive in self refresh");
  a_lp_cause: assert property ($rose(self_refresh) || $rose(power_down) |->
    cke_lo >= 8'h03) else $error("low power without cke low");
endmodule
bind ddr2_burst_dev ddr2_burst_dev_sva u_sva (.clk(clk), .reset_n(reset_n),
  .ck_pin(ck_pin), .cmd_pin(cmd_pin), .data_out(data_out), .dqs_oe(dqs_oe),
  .dq_oe(dq_oe), .self_refresh(self_refresh), .power_down(power_down));
`default_nettype wire

// ===== ddr2_burst_dev_tb.sv
/* self-checking bench for the DDR2 burst device.
   assumes the controller model makes a 320 ns memory clock. */
`timescale 1ns/1ps
`default_nettype none
module ddr2_burst_dev_tb;
  logic clk;
  logic reset_n;
  logic ce;
  wire logic ck_pin;
  wire ddr2_burst_pkg::cmd_pins_t cmd_pin;
  wire ddr2_burst_pkg::data_pins_t data_in;
  wire ddr2_burst_pkg::data_pins_t data_out;
  wire logic [1:0] dqs_oe;
  wire logic [15:0] dq_oe;
  wire logic self_refresh;
  wire logic power_down;
  int n_mismatch = 0;
  int compares = 0;
  int bl = 8;
  logic il = 1'b0;
  logic [31:0] seed = 32'h30;
  logic [15:0] mem [64];
  logic [15:0] exq[$];
  logic open_b [4] = '{4{1'b0}};
  logic row_b [4];
  ddr2_burst_dev u_dut (.clk(clk), .reset_n(reset_n), .ce(ce),
    .ck_pin(ck_pin), .cmd_pin(cmd_pin), .data_in(data_in),
    .data_out(data_out), .dqs_oe(dqs_oe), .dq_oe(dq_oe),
    .self_refresh(self_refresh), .power_down(power_down));
  ddr2_ctrl_model u_ctrl (.clk(clk), .data_out(data_out), .dqs_oe(dqs_oe),
    .dq_oe(dq_oe), .ck_pin(ck_pin), .cmd_pin(cmd_pin), .data_in(data_in));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==================================================
  // reference model
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int loc(int b, int c, int i);
    int k;
    if (il) k = c ^ i;
    else if (bl == 8) k = (c + i) % 8;
    else k = (c & 4) | ((c + i) % 4);
    return b * 16 + row_b[b] * 8 + k;
  endfunction
  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==================================================
  // command tasks
  task automatic nop(input logic cke);
    u_ctrl.cmd(ddr2_burst_pkg::CMD_NOP, 2'h0, 13'h0, cke);
  endtask
  task automatic lmr(input logic [1:0] b, input int len, input logic ilv);
    u_ctrl.cmd(ddr2_burst_pkg::CMD_LMR, b,
               {9'h0, ilv, (len == 8) ? 3'h3 : 3'h2}, 1'b1);
    if (b == 2'h0) bl = len;
    if (b == 2'h0) il = ilv;
  endtask
  task automatic act(input int b, input logic r);
    u_ctrl.cmd(ddr2_burst_pkg::CMD_ACT, 2'(b), {12'h0, r}, 1'b1);
    open_b[b] = 1'b1;
    row_b[b] = r;
  endtask
  task automatic pre(input int b, input logic all);
    u_ctrl.cmd(ddr2_burst_pkg::CMD_PRE, 2'(b), {2'h0, all, 10'h0}, 1'b1);
    if (all) open_b = '{4{1'b0}};
    else open_b[b] = 1'b0;
  endtask
  task automatic wr(input int b, input int c, input logic ap);
    logic [15:0] w[8];
    for (int i = 0; i < 8; i++) w[i] = 16'(rnd());
    u_ctrl.cmd(ddr2_burst_pkg::CMD_WR, 2'(b), {2'h0, ap, 7'h0, 3'(c)}, 1'b1);
    u_ctrl.burst(w, bl);
    if (open_b[b]) for (int i = 0; i < bl; i++) mem[loc(b, c, i)] = w[i];
    if (ap) open_b[b] = 1'b0;
  endtask
  task automatic rd_go(input int b, input int c, input logic ap, input int n);
    u_ctrl.cmd(ddr2_burst_pkg::CMD_RD, 2'(b), {2'h0, ap, 7'h0, 3'(c)}, 1'b1);
    if (open_b[b]) for (int i = 0; i < n; i++) exq.push_back(mem[loc(b, c, i)]);
    if (ap) open_b[b] = 1'b0;
  endtask
  task automatic rd_end();
    repeat (120) @(negedge clk);
    chk("beats", 16'(exq.size()), 16'(u_ctrl.rdq.size()));
    foreach (exq[i]) chk("rdata", exq[i], u_ctrl.rdq[i]);
    exq.delete();
    u_ctrl.rdq.delete();
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  // ==================================================
  // scenarios
  initial begin
    int c;
    reset_n = 1'b0;
    ce = 1'b1;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    chk("dqs_oe", 16'h0, 16'(dqs_oe));
    ce = 1'b0;
    repeat (5) @(negedge clk);
    ce = 1'b1;
    act(0, 1'b0);
    for (int m = 0; m < 4; m++) begin
      c = int'(rnd() % 8);
      lmr(2'h0, m[1] ? 4 : 8, m[0]);
      wr(m, c, 1'b0);
      rd_go(m, c ^ 1, 1'b0, bl);
      if (m < 3) act(m + 1, 1'(m + 1));
      rd_end();
    end
    lmr(2'h0, 8, 1'b0);
    lmr(2'h1, 4, 1'b1);
    rd_go(1, 0, 1'b0, 4);
    // cut lands once the first burst has shown four beats
    nop(1'b1);
    rd_go(1, 4, 1'b0, 8);
    rd_end();
    pre(3, 1'b0);
    rd_go(3, 2, 1'b0, 8);
    rd_go(0, 3, 1'b0, 8);
    rd_end();
    rd_go(1, 5, 1'b1, 8);
    rd_end();
    act(1, 1'b1);
    wr(1, 6, 1'b1);
    rd_go(1, 6, 1'b0, 8);
    rd_end();
    pre(0, 1'b1);
    rd_go(2, 1, 1'b0, 8);
    rd_end();
    u_ctrl.cmd(ddr2_burst_pkg::CMD_REF, 2'h0, 13'h0, 1'b0);
    repeat (16) @(negedge clk);
    chk("self_refresh", 16'h1, 16'(self_refresh));
    nop(1'b1);
    repeat (16) @(negedge clk);
    chk("self_refresh", 16'h0, 16'(self_refresh));
    act(0, 1'b0);
    rd_go(0, 3, 1'b0, 8);
    rd_end();
    nop(1'b0);
    repeat (16) @(negedge clk);
    chk("power_down", 16'h1, 16'(power_down));
    nop(1'b1);
    repeat (16) @(negedge clk);
    chk("power_down", 16'h0, 16'(power_down));
    end_sim();
  end
endmodule
`default_nettype wire

// ===== ddr2_burst_pkg.sv
/*
  Package for the DDR2 burst interface model: command codes, geometry,
  timing counts and the packed structs that carry command and data.
  Assumes a 25 MHz system clock that samples the memory clock pin.
*/
`default_nettype none
package ddr2_burst_pkg;
  // =====================================================
  // geometry
  localparam int DQ_W = 16;
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int ADDR_W = 13;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int COL_W = 4;
  localparam int WORD_W = 4 * DQ_W;
  localparam int AP_BIT = 10;
  localparam int MEM_DEPTH = 64;
  localparam int MEM_AW = 6;
  localparam int ROW_KEEP = 2;
  // =====================================================
  // mode register fields (load mode writes register picked by bank lines)
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam logic [2:0] MR_BL4 = 3'h2;
  localparam logic [2:0] MR_BL8 = 3'h3;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0003;
  localparam logic [1:0] MR_SEL_MODE = 2'h0;
  // =====================================================
  // timing
  localparam int CLK_NS = 40;
  localparam int PRE_NS = 80;
  localparam int PRE_CYC = (PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] READ_LAT = 4'h2;
  // =====================================================
  // commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;

  typedef struct packed {
    logic cke;
    logic [3:0] code;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] dqs;
  } data_pins_t;
endpackage
`default_nettype wire

// ===== ddr2_ctrl_model.sv
/* controller model: memory clock, commands, write bursts, read capture.
   assumes the device toggles its strobe once per read beat. */
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_model (
  input wire logic clk, // system clock
  input wire ddr2_burst_pkg::data_pins_t data_out, // device drive
  input wire logic [1:0] dqs_oe, // device strobe enable
  input wire logic [15:0] dq_oe, // device data enable
  output logic ck_pin, // memory clock
  output ddr2_burst_pkg::cmd_pins_t cmd_pin, // command pins
  output wire ddr2_burst_pkg::data_pins_t data_in // resolved wire level
);
  logic [15:0] dq_d = 16'h0;
  logic [1:0] dqs_d = 2'h0;
  logic wr_on = 1'b0;
  logic last_s = 1'b0;
  logic [15:0] rdq[$];
  assign data_in.dq = (dq_oe & data_out.dq) | (~dq_oe & dq_d);
  assign data_in.dqs = (dqs_oe & data_out.dqs) | (~dqs_oe & dqs_d);
  initial begin
    ck_pin = 1'b0;
    cmd_pin = '{1'b1, ddr2_burst_pkg::CMD_NOP, 2'h0, 13'h0};
    forever begin
      repeat (4) @(negedge clk);
      ck_pin = ~ck_pin;
    end
  end
  // released data lines wander so a stale value never passes
  always @(negedge clk) begin
    if (!wr_on) dq_d <= dq_d + 16'h1357;
    if (dqs_oe[0] && data_out.dqs[0] != last_s) rdq.push_back(data_out.dq);
    last_s <= dqs_oe[0] & data_out.dqs[0];
  end
  task automatic cmd(input logic [3:0] code, input logic [1:0] b,
                     input logic [12:0] a, input logic cke);
    @(negedge ck_pin);
    cmd_pin = '{cke, code, b, a};
    @(negedge ck_pin);
    cmd_pin = '{cke, ddr2_burst_pkg::CMD_NOP, ~b, ~a};
  endtask
  task automatic burst(input logic [15:0] w[8], input int n);
    wr_on = 1'b1;
    for (int i = 0; i < n; i++) begin
      dq_d <= w[i]; // nba so the idle wander cannot overwrite beat 0
      repeat (4) @(negedge clk);
      dqs_d = ~dqs_d;
      repeat (4) @(negedge clk);
    end
    wr_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== ddr2_pin_sync.sv
/*
  Three-flop synchroniser with agreement filter for pin inputs.
  Assumes clk is the system clock; input is asynchronous to it.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr2_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // async input
  output logic [W-1:0] q // filtered level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // =====================================================
  // stages; first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts only when second and third agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          q[i] <= 1'b0;
        end else if (ce && (s2_q[i] == s3_q[i])) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
